// ==== src/pmsc_defs.svh ====
// constants of the port PHY crossover and special control register bank
// assumes it is included by bare name from the top module, the host model and the bench
`ifndef PMSC_DEFS_SVH
`define PMSC_DEFS_SVH

// ******************************
// register map
// ******************************
`define PMSC_REG_INDEX 5'h1b
`define PMSC_REG_WIDTH 16
`define PMSC_BIT_SRC_SEL 15
`define PMSC_BIT_AUTO_EN 14
`define PMSC_BIT_MAN_STATE 13
`define PMSC_BIT_HB_DIS 11
`define PMSC_BIT_PLL_LOCK 10
`define PMSC_BIT_POLARITY 4
`define PMSC_CTRL_RESET 1'h0

// ******************************
// management frame
// ******************************
`define PMSC_OP_WRITE 2'h1
`define PMSC_OP_READ 2'h2
`define PMSC_HDR_LAST 5'h0b
`define PMSC_TA_LAST 5'h01
`define PMSC_DATA_LAST 5'h0f

`endif

// ==== src/pmsc_pkg.sv ====
// types of the port PHY crossover and special control register bank
// assumes the constants header sits beside it
package pmsc_pkg;

   // one-hot management frame states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_HDR   = 5'h04,
      ST_TA    = 5'h08,
      ST_DATA  = 5'h10
   } pmsc_state_t;

   typedef struct packed {
      logic mdc_s1;
      logic mdc_s2;
      logic mdc_s3;
      logic mdio_s1;
      logic mdio_s2;
      logic pol_s1;
      logic pol_s2;
      pmsc_state_t state;
      logic [4:0] cnt;
      logic [15:0] shreg;
      logic last_bit;
      logic is_read;
      logic is_write;
      logic hit;
      logic mdio_oe;
      logic mdio_out;
      logic src_sel;
      logic auto_en;
      logic man_state;
      logic hb_dis;
      logic pll_lock;
      logic cross_auto;
      logic cross_on;
      logic strap_auto;
   } pmsc_regs_t;

endpackage : pmsc_pkg

// ==== src/pmsc_top.sv ====
// crossover source, heartbeat, PLL lock and polarity register of one PHY
// assumes MDC/MDIO and the polarity detector are asynchronous pins, while
// the address, straps and soft reset come from logic on CORE_CLK
// limitation: each MDC half period must last at least three core clocks,
// since the pin is sampled through two flops and an edge flop
// only index 27 of the configured address is answered; the rest is left
// to the neighbouring registers
`timescale 1ns/1ps
`include "pmsc_defs.svh"

module pmsc_top (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // management pins
   input wire logic MDC,
   input wire logic MDIO_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE,
   // configuration
   input wire logic [4:0] PHY_ADDR,
   input wire logic PHY_SOFT_RESET,
   input wire logic AUTO_MDIX_STRAP,
   input wire logic MANUAL_MDIX_STRAP,
   // analog side
   input wire logic POLARITY_REVERSED_IN,
   output logic CROSSOVER_AUTO,
   output logic CROSSOVER_ON,
   output logic HEARTBEAT_TEST_DISABLE,
   output logic RX_PLL_REF_LOCK,
   // hardware configuration status
   output logic HARDWARE_CONFIGURATION_AUTO_STRAP
);

   // ******************************
   // state
   // ******************************
   // every flop of the block lives in this one struct
   pmsc_pkg::pmsc_regs_t r_q;
   pmsc_pkg::pmsc_regs_t r_d;

   // ******************************
   // derived signals
   // ******************************
   // synchronised pin views
   logic mdc_rise;
   logic bit_in;
   logic pol_now;

   // frame header fields
   logic [11:0] hdr;
   logic [1:0] hdr_op;
   logic [4:0] hdr_phy;
   logic [4:0] hdr_index;
   logic hdr_is_read;
   logic hdr_is_write;
   logic addr_match;
   logic index_match;
   logic frame_hit;

   // frame progress
   logic frame_open;
   logic hdr_done;
   logic ta_last;
   logic data_last;
   logic commit_write;
   logic drive_read;
   logic [4:0] cnt_next;

   // data words
   logic [15:0] wr_val;
   logic [15:0] rd_ctrl;
   logic [15:0] rd_status;
   logic [15:0] rd_val;

   // crossover mode sources
   logic pin_auto;
   logic pin_on;
   logic [1:0] reg_code;

   // ******************************
   // pin synchronisers
   // ******************************
   // a rising edge is taken once the second stage sees the new level
   assign mdc_rise = r_q.mdc_s2 & ~r_q.mdc_s3;
   assign bit_in = r_q.mdio_s2;

   // polarity is a slow level from the analog side
   assign pol_now = r_q.pol_s2;

   // ******************************
   // header decode
   // ******************************
   assign hdr = {r_q.shreg[10:0], bit_in};
   assign hdr_op = hdr[11:10];
   assign hdr_phy = hdr[9:5];
   assign hdr_index = hdr[4:0];
   assign hdr_is_read = hdr_op == `PMSC_OP_READ;
   assign hdr_is_write = hdr_op == `PMSC_OP_WRITE;
   assign addr_match = hdr_phy == PHY_ADDR;
   // other indices belong to neighbouring registers
   assign index_match = hdr_index == `PMSC_REG_INDEX;
   assign frame_hit = addr_match & index_match;

   // ******************************
   // frame progress
   // ******************************
   // preamble of ones, then a zero opens the frame
   assign frame_open = r_q.last_bit & ~bit_in;
   assign hdr_done = r_q.cnt == `PMSC_HDR_LAST;
   assign ta_last = r_q.cnt == `PMSC_TA_LAST;
   assign data_last = r_q.cnt == `PMSC_DATA_LAST;
   assign commit_write = data_last & r_q.is_write & r_q.hit;
   assign drive_read = r_q.is_read & r_q.hit;
   assign cnt_next = r_q.cnt + 5'h01;
   assign wr_val = {r_q.shreg[14:0], bit_in};

   // ******************************
   // pin crossover mode
   // ******************************
   // auto strap high overrides whatever the manual strap says
   assign pin_auto = AUTO_MDIX_STRAP;
   assign pin_on = ~AUTO_MDIX_STRAP & MANUAL_MDIX_STRAP;

   // ******************************
   // read image
   // ******************************
   // reserved positions stay zero in both halves
   always_comb begin
      rd_ctrl = 16'h0000;
      rd_ctrl[`PMSC_BIT_SRC_SEL] = r_q.src_sel;
      rd_ctrl[`PMSC_BIT_AUTO_EN] = r_q.auto_en;
      rd_ctrl[`PMSC_BIT_MAN_STATE] = r_q.man_state;
      rd_ctrl[`PMSC_BIT_HB_DIS] = r_q.hb_dis;
      rd_ctrl[`PMSC_BIT_PLL_LOCK] = r_q.pll_lock;
   end

   // read-only indication
   always_comb begin
      rd_status = 16'h0000;
      rd_status[`PMSC_BIT_POLARITY] = pol_now;
   end

   assign rd_val = rd_ctrl | rd_status;

   // ******************************
   // next state
   // ******************************
   always_comb begin
      r_d = r_q;
      reg_code = 2'h0;

      // first stage feeds only the second stage
      r_d.mdc_s1 = MDC;
      r_d.mdc_s2 = r_q.mdc_s1;
      r_d.mdc_s3 = r_q.mdc_s2;
      r_d.mdio_s1 = MDIO_IN;
      r_d.mdio_s2 = r_q.mdio_s1;
      r_d.pol_s1 = POLARITY_REVERSED_IN;
      r_d.pol_s2 = r_q.pol_s1;

      // status copy of the latched strap, one flop behind the pin
      r_d.strap_auto = AUTO_MDIX_STRAP;

      if (mdc_rise) begin
         r_d.last_bit = bit_in;
         unique case (r_q.state)

            // wait for the frame start, line released
            pmsc_pkg::ST_IDLE: begin
               r_d.mdio_oe = 1'b0;
               r_d.mdio_out = 1'b0;
               if (frame_open) begin
                  r_d.state = pmsc_pkg::ST_START;
               end
            end

            // second start bit must be a one
            pmsc_pkg::ST_START: begin
               r_d.cnt = 5'h00;
               // no decision of an earlier frame may leak into this one
               r_d.is_read = 1'b0;
               r_d.is_write = 1'b0;
               r_d.hit = 1'b0;
               if (bit_in) begin
                  r_d.state = pmsc_pkg::ST_HDR;
               end else begin
                  r_d.state = pmsc_pkg::ST_IDLE;
               end
            end

            // opcode, PHY address and register index, MSB first
            pmsc_pkg::ST_HDR: begin
               r_d.shreg = {r_q.shreg[14:0], bit_in};
               r_d.cnt = cnt_next;
               if (hdr_done) begin
                  r_d.is_read = hdr_is_read;
                  r_d.is_write = hdr_is_write;
                  r_d.hit = frame_hit;
                  r_d.cnt = 5'h00;
                  r_d.state = pmsc_pkg::ST_TA;
               end
            end

            // turnaround: host lets go, then a read drives a zero
            pmsc_pkg::ST_TA: begin
               r_d.cnt = cnt_next;
               if (!ta_last) begin
                  // first turnaround bit is left floating
                  r_d.mdio_oe = drive_read;
                  r_d.mdio_out = 1'b0;
               end else begin
                  // word is captured here, polarity frozen for this read
                  r_d.mdio_out = rd_val[15];
                  r_d.shreg = {rd_val[14:0], 1'b0};
                  r_d.cnt = 5'h00;
                  r_d.state = pmsc_pkg::ST_DATA;
               end
            end

            // sixteen data bits: shift out a read, shift in a write
            pmsc_pkg::ST_DATA: begin
               r_d.shreg = wr_val;
               r_d.mdio_out = r_q.shreg[15];
               r_d.cnt = cnt_next;
               if (data_last) begin
                  r_d.mdio_oe = 1'b0;
                  r_d.mdio_out = 1'b0;
                  r_d.state = pmsc_pkg::ST_IDLE;
                  r_d.last_bit = 1'b0;
               end
               if (commit_write) begin
                  // reserved positions are simply not stored
                  r_d.src_sel = wr_val[`PMSC_BIT_SRC_SEL];
                  r_d.auto_en = wr_val[`PMSC_BIT_AUTO_EN];
                  r_d.man_state = wr_val[`PMSC_BIT_MAN_STATE];
                  r_d.hb_dis = wr_val[`PMSC_BIT_HB_DIS];
                  r_d.pll_lock = wr_val[`PMSC_BIT_PLL_LOCK];
               end
            end

            // a corrupted state code drops the frame and the line
            default: begin
               r_d.state = pmsc_pkg::ST_IDLE;
               r_d.mdio_oe = 1'b0;
            end
         endcase
      end

      // soft reset outranks a write landing in the same cycle
      if (PHY_SOFT_RESET) begin
         r_d.src_sel = `PMSC_CTRL_RESET;
         r_d.auto_en = `PMSC_CTRL_RESET;
         r_d.man_state = `PMSC_CTRL_RESET;
         r_d.hb_dis = `PMSC_CTRL_RESET;
         r_d.pll_lock = `PMSC_CTRL_RESET;
      end

      // crossover mode from next bits, so pins change in the same cycle as the control bits
      reg_code = {r_d.auto_en, r_d.man_state};
      if (r_d.src_sel) begin
         unique case (reg_code)
            2'h0: begin
               r_d.cross_auto = 1'b0;
               r_d.cross_on = 1'b0;
            end
            2'h1: begin
               r_d.cross_auto = 1'b0;
               r_d.cross_on = 1'b1;
            end
            // reserved 11 falls to automatic: the enable bit wins
            2'h2, 2'h3: begin
               r_d.cross_auto = 1'b1;
               r_d.cross_on = 1'b0;
            end
         endcase
      end else begin
         r_d.cross_auto = pin_auto;
         r_d.cross_on = pin_on;
      end
   end

   // ******************************
   // state register
   // ******************************
   // async clear only, state to ST_IDLE; everything else takes the computed copy
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         r_q <= '0;
         r_q.state <= pmsc_pkg::ST_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   // ******************************
   // outputs
   // ******************************
   // management pins
   assign MDIO_OUT = r_q.mdio_out;
   assign MDIO_OE = r_q.mdio_oe;

   // analog side
   assign CROSSOVER_AUTO = r_q.cross_auto;
   assign CROSSOVER_ON = r_q.cross_on;
   assign HEARTBEAT_TEST_DISABLE = r_q.hb_dis;
   assign RX_PLL_REF_LOCK = r_q.pll_lock;

   // status
   assign HARDWARE_CONFIGURATION_AUTO_STRAP = r_q.strap_auto;

endmodule : pmsc_top

// ==== bench/pmsc_props.sv ====
// port checker of the crossover control register bank
// assumes it is bound to pmsc_top on the single core clock
`timescale 1ns/1ps
module pmsc_props (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic MDC,
   input wire logic PHY_SOFT_RESET,
   input wire logic AUTO_MDIX_STRAP,
   input wire logic MANUAL_MDIX_STRAP,
   input wire logic MDIO_OUT,
   input wire logic MDIO_OE,
   input wire logic CROSSOVER_AUTO,
   input wire logic CROSSOVER_ON,
   input wire logic HEARTBEAT_TEST_DISABLE,
   input wire logic RX_PLL_REF_LOCK,
   input wire logic HARDWARE_CONFIGURATION_AUTO_STRAP
);
   logic [7:0] oe_n_q;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // 17 bit periods (turnaround and 16 data) of 11 clocks, a stuck driver overruns this
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) oe_n_q <= 8'h00;
      else oe_n_q <= MDIO_OE ? oe_n_q + 8'h01 : 8'h00;
   end
   property p_hw;
      1 |=> HARDWARE_CONFIGURATION_AUTO_STRAP == $past(AUTO_MDIX_STRAP);
   endproperty
   a_hw: assert property (p_hw) else $error("strap status");
   property p_excl; CROSSOVER_AUTO |-> !CROSSOVER_ON; endproperty
   a_excl: assert property (p_excl) else $error("auto and on");
   property p_clr;
      PHY_SOFT_RESET |=> !HEARTBEAT_TEST_DISABLE && !RX_PLL_REF_LOCK;
   endproperty
   a_clr: assert property (p_clr) else $error("soft reset");
   property p_pin;
      (PHY_SOFT_RESET && $stable(AUTO_MDIX_STRAP)
         && $stable(MANUAL_MDIX_STRAP)) [*3] |->
         CROSSOVER_AUTO == AUTO_MDIX_STRAP && CROSSOVER_ON ==
         (MANUAL_MDIX_STRAP && !AUTO_MDIX_STRAP);
   endproperty
   a_pin: assert property (p_pin) else $error("pin mode");
   property p_oe_on; $rose(MDIO_OE) |-> !MDIO_OUT && MDC; endproperty
   a_oe_on: assert property (p_oe_on) else $error("turnaround");
   property p_oe_len; oe_n_q <= 8'hbe; endproperty
   a_oe_len: assert property (p_oe_len) else $error("drive long");
   property p_hb;
      $changed(HEARTBEAT_TEST_DISABLE) |-> MDC || $past(PHY_SOFT_RESET);
   endproperty
   a_hb: assert property (p_hb) else $error("heartbeat");
   property p_pll;
      $changed(RX_PLL_REF_LOCK) |-> MDC || $past(PHY_SOFT_RESET);
   endproperty
   a_pll: assert property (p_pll) else $error("pll lock");
endmodule : pmsc_props
bind pmsc_top pmsc_props u_pmsc_props (.CORE_CLK, .RESET_N, .MDC,
   .PHY_SOFT_RESET, .AUTO_MDIX_STRAP, .MANUAL_MDIX_STRAP, .MDIO_OUT,
   .MDIO_OE, .CROSSOVER_AUTO, .CROSSOVER_ON, .HEARTBEAT_TEST_DISABLE,
   .RX_PLL_REF_LOCK, .HARDWARE_CONFIGURATION_AUTO_STRAP);

// ==== bench/pmsc_mdio_host.sv ====
// management host model that clocks whole frames onto the data wire
// assumes the bench resolves the wire with a pull-up
`timescale 1ns/1ps
`include "pmsc_defs.svh"
module pmsc_mdio_host (
   input wire logic clk,
   input wire logic mdio_w,
   output logic mdc = 1'b0,
   output logic h_d = 1'b1,
   output logic h_oe = 1'b0
);
   // clock stands low between frames, line released to the pull-up
   task automatic xfer(input logic rd, input logic [4:0] pa, ra,
      input logic [15:0] wd, output logic [15:0] q);
      logic [33:0] w;
      w = {4'hd, rd ? `PMSC_OP_READ : `PMSC_OP_WRITE, pa, ra, 2'h2, wd};
      q = 16'h0000;
      for (int i = 33; i >= 0; i--) begin
         @(posedge clk);
         mdc <= 1'b0;
         h_oe <= !(rd && i < 18);
         h_d <= w[i];
         repeat (5) @(posedge clk);
         mdc <= 1'b1;
         q = {q[14:0], mdio_w};
         repeat (5) @(posedge clk);
      end
      @(posedge clk);
      mdc <= 1'b0;
      h_oe <= 1'b0;
   endtask : xfer
endmodule : pmsc_mdio_host

// ==== bench/phy_mdix_special_control_bench.sv ====
// self-checking bench of the crossover control register bank
// assumes the host model and checker are compiled beside it
`timescale 1ns/1ps
`include "pmsc_defs.svh"
module phy_mdix_special_control_bench;
   logic clk = 1'b0, rst_n = 1'b0, srst = 1'b0, pol = 1'b0;
   logic sa = 1'b0, sm = 1'b0, mdc, h_d, h_oe, oe, out, mdio_w;
   logic xa, xo, hb, pll, hw;
   logic [15:0] rd;
   int fail_count = 0, cmp_count = 0;
   localparam logic [4:0] A = 5'h05;
   localparam logic [4:0] I = `PMSC_REG_INDEX;
   always #20 clk = ~clk;
   assign mdio_w = oe ? out : (h_oe ? h_d : 1'b1);
   pmsc_mdio_host u_pmsc_mdio_host (.clk, .mdio_w, .mdc, .h_d, .h_oe);
   pmsc_top u_pmsc_top (.CORE_CLK(clk), .RESET_N(rst_n), .MDC(mdc),
      .MDIO_IN(mdio_w), .MDIO_OUT(out), .MDIO_OE(oe), .PHY_ADDR(A),
      .PHY_SOFT_RESET(srst), .AUTO_MDIX_STRAP(sa),
      .MANUAL_MDIX_STRAP(sm), .POLARITY_REVERSED_IN(pol),
      .CROSSOVER_AUTO(xa), .CROSSOVER_ON(xo), .HEARTBEAT_TEST_DISABLE(hb),
      .RX_PLL_REF_LOCK(pll), .HARDWARE_CONFIGURATION_AUTO_STRAP(hw));
   task automatic chk(input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [4:0] pa, input logic [15:0] exp);
      u_pmsc_mdio_host.xfer(1'b1, pa, I, 16'h0000, rd);
      chk(rd, exp);
   endtask : rdc
   // pin mode under a held soft reset, every strap pair
   task automatic t_pins;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         sa <= k[1];
         sm <= k[0];
         srst <= 1'b1;
         repeat (4) @(posedge clk);
         @(negedge clk);
         chk({11'h000, xa, xo, hb, pll, hw}, {11'h000, k[1], k == 1,
            2'h0, k[1]});
      end
      @(posedge clk);
      srst <= 1'b0;
      rdc(A, 16'h0010);
      $display("t_pins done");
   endtask : t_pins
   // register mode overrides an auto strap; reserved bits written high
   task automatic t_reg;
      for (int k = 0; k < 3; k++) begin
         u_pmsc_mdio_host.xfer(1'b0, A, I, {1'b1, k[1:0], 1'b1, k[0],
            !k[0], 10'h3ff}, rd);
         chk({12'h000, xa, xo, hb, pll}, {12'h000, k[1], k == 1, k[0],
            !k[0]});
         rdc(A, {1'b1, k[1:0], 1'b0, k[0], !k[0], 5'h00, 1'b1,
            4'h0});
      end
      $display("t_reg done");
   endtask : t_reg
   // foreign address and index are not stored; a foreign address is not answered
   task automatic t_addr;
      u_pmsc_mdio_host.xfer(1'b0, A ^ 5'h01, I, 16'h0000, rd);
      u_pmsc_mdio_host.xfer(1'b0, A, 5'h1a, 16'h0000, rd);
      rdc(A ^ 5'h10, 16'hffff);
      rdc(A, 16'hc410);
      $display("t_addr done");
   endtask : t_addr
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(A, 16'h0000);
      pol <= 1'b1;
      sa <= 1'b1;
      t_reg;
      t_addr;
      t_pins;
      final_report;
   end
endmodule : phy_mdix_special_control_bench
